// [core/mpc_monitor.sv]
`timescale 1ns/1ps
module mpc_monitor (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // mode and line-sense sense of truth
  input  wire logic [2:0] mode,
  input  wire logic       line_true_low,
  // synchronised pin level and comparator levels
  input  wire logic       pin_hi,
  input  wire logic       above_115,
  input  wire logic       above_125,
  input  wire logic       above_135,
  // monitor results
  output logic            flag,
  output logic            ov,
  output logic            uv
);
  logic high_ff;
  logic nxt_high;
  wire  upper_band = (mode == mpc_pkg::MODE_PUV) || (mode == mpc_pkg::MODE_NOV);
  wire  over_hi    = upper_band ? above_135 : above_125;
  wire  over_lo    = upper_band ? above_125 : above_115;
  wire  line_mode  = (mode == mpc_pkg::MODE_LINE0) || (mode == mpc_pkg::MODE_LINE1);
  wire  line_flag  = line_true_low ? ~pin_hi : pin_hi;

  // hysteresis: set above the high threshold, clear below the low one
  assign nxt_high = over_hi ? 1'b1 : (over_lo ? high_ff : 1'b0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_ff <= 1'b0;
    end else begin
      high_ff <= nxt_high;
    end
  end

  // outputs decode straight from the mode field
  always_comb begin
    flag = high_ff;
    ov   = 1'b0;
    uv   = 1'b0;
    unique case (mode)
      mpc_pkg::MODE_LINE0, mpc_pkg::MODE_LINE1: flag = line_flag;
      mpc_pkg::MODE_POV:  ov = high_ff;
      mpc_pkg::MODE_PUV:  uv = ~high_ff;
      mpc_pkg::MODE_NOV:  ov = ~high_ff;
      mpc_pkg::MODE_NUV:  uv = high_ff;
      mpc_pkg::MODE_FLAG: flag = high_ff;
      mpc_pkg::MODE_INV:  flag = ~high_ff;
    endcase
  end

  // assertions
  pov_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mpc_pkg::MODE_POV) |-> (ov == flag) && !uv)
    else $error("overvoltage output does not follow flag");
  inv_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mpc_pkg::MODE_INV) && $stable(mode) && $past(above_125) |-> !flag && !ov && !uv)
    else $error("inverted flag high above threshold");
  puv_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mpc_pkg::MODE_PUV) && $stable(mode) && $past(above_135) |-> flag && !ov && !uv)
    else $error("undervoltage output wrong above upper threshold");
endmodule

// [core/mpc_pkg.sv]
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package mpc_pkg;
  // register addresses and eeprom boot locations
  localparam logic [7:0]  PIN_FUNC_ADDR   = 8'h0D;
  localparam logic [7:0]  MON_DELAY_ADDR  = 8'h0E;
  localparam logic [15:0] PIN_FUNC_EE     = 16'h810D;
  localparam logic [15:0] MON_DELAY_EE    = 16'h810E;
  localparam logic [7:0]  PIN_FUNC_RST    = 8'h01;
  localparam logic [7:0]  MON_DELAY_RST   = 8'h00;
  // pin_function_config fields
  localparam int PSON_SRC_BIT   = 7;
  localparam int BLANK_MODE_BIT = 4;
  localparam int SUPERVISE_INPUT_FIRST_LSB       = 1;
  localparam int SERIAL_BIT     = 0;
  // monitor_delay_config fields
  localparam int SUPERVISE_INPUT_SECOND_LSB       = 5;
  localparam int SUPERVISE_INPUT_THIRD_LSB       = 2;
  localparam int DELAY_LSB      = 0;
  // monitor mode codes
  localparam logic [2:0] MODE_LINE0 = 3'h0;
  localparam logic [2:0] MODE_LINE1 = 3'h1;
  localparam logic [2:0] MODE_POV   = 3'h2;
  localparam logic [2:0] MODE_PUV   = 3'h3;
  localparam logic [2:0] MODE_NOV   = 3'h4;
  localparam logic [2:0] MODE_NUV   = 3'h5;
  localparam logic [2:0] MODE_FLAG  = 3'h6;
  localparam logic [2:0] MODE_INV   = 3'h7;
  // output-good delay choices in ms
  localparam logic [10:0] DLY_MS_00 = 11'd400;
  localparam logic [10:0] DLY_MS_01 = 11'd200;
  localparam logic [10:0] DLY_MS_10 = 11'd800;
  localparam logic [10:0] DLY_MS_11 = 11'd1600;
  // clock rate and millisecond tick
  localparam int CLK_HZ       = 50000000;
  localparam int MS_PER_S     = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / MS_PER_S;
  // boot loader states, gray along the path
  typedef enum logic [1:0] {
    BOOT_PIN   = 2'h0,
    BOOT_DELAY = 2'h1,
    BOOT_RUN   = 2'h3
  } mpc_boot_t;
  // delay field to milliseconds
  function automatic logic [10:0] dly_ms(input logic [1:0] code);
    unique case (code)
      2'h0: dly_ms = DLY_MS_00;
      2'h1: dly_ms = DLY_MS_01;
      2'h2: dly_ms = DLY_MS_10;
      2'h3: dly_ms = DLY_MS_11;
    endcase
  endfunction
endpackage

// [core/mpc_top.sv]
`timescale 1ns/1ps
module mpc_top #(
  parameter int TICK_CYCLES = mpc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_ready,
  // eeprom boot read port
  output logic             ee_rd_req,
  output logic      [15:0] ee_rd_addr,
  input  wire logic        ee_rd_valid,
  input  wire logic [7:0]  ee_rd_data,
  // monitor pins and comparators, index 0 is monitor one
  input  wire logic [2:0]  mon_pin_level,
  input  wire logic [2:0]  mon_above_115,
  input  wire logic [2:0]  mon_above_125,
  input  wire logic [2:0]  mon_above_135,
  // monitor results
  output logic      [2:0]  mon_flag,
  output logic      [2:0]  mon_ov,
  output logic      [2:0]  mon_uv,
  // power control
  input  wire logic        host_power_on_bit,
  input  wire logic        line_power_good,
  input  wire logic        output_good_request,
  output logic             power_on_request,
  output logic             blank_start,
  output logic             output_power_good,
  // serial pins
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             serial_pins_mode
);
  //----------------------------------------------------------------------------
  // reset and input synchronisers
  //----------------------------------------------------------------------------
  logic [1:0]  rst_sync_ff;
  logic [13:0] in_meta_ff;
  logic [13:0] in_sync_ff;
  wire         rst_n = rst_sync_ff[1];
  wire  [13:0] in_raw = {mon_pin_level, mon_above_115, mon_above_125, mon_above_135,
                         scl_in, line_power_good};

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // two-flop synchroniser for the monitor, scl and line-good pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_ff <= 14'h0002;  // scl idles high, no false fall after reset
      in_sync_ff <= 14'h0002;  // scl idles high, no false fall after reset
    end else begin
      in_meta_ff <= in_raw;
      in_sync_ff <= in_meta_ff;
    end
  end

  wire [2:0] pin_s   = in_sync_ff[13:11];
  wire [2:0] a115_s  = in_sync_ff[10:8];
  wire [2:0] a125_s  = in_sync_ff[7:5];
  wire [2:0] a135_s  = in_sync_ff[4:2];
  wire       scl_s   = in_sync_ff[1];
  wire       lgood_s = in_sync_ff[0];

  //----------------------------------------------------------------------------
  // boot load and register file
  //----------------------------------------------------------------------------
  mpc_pkg::mpc_boot_t boot_ff;
  mpc_pkg::mpc_boot_t nxt_boot;
  logic [7:0] pin_func_ff;
  logic [7:0] mon_delay_ff;
  logic [7:0] rdata_ff;
  wire        booting   = (boot_ff != mpc_pkg::BOOT_RUN);
  wire        ld_pin    = (boot_ff == mpc_pkg::BOOT_PIN) && ee_rd_valid;
  wire        ld_delay  = (boot_ff == mpc_pkg::BOOT_DELAY) && ee_rd_valid;
  wire        wr_pin    = reg_wr && !booting && (reg_addr == mpc_pkg::PIN_FUNC_ADDR);
  wire        wr_delay  = reg_wr && !booting && (reg_addr == mpc_pkg::MON_DELAY_ADDR);
  wire [7:0]  rd_mux    = (reg_addr == mpc_pkg::PIN_FUNC_ADDR)  ? pin_func_ff :
                          (reg_addr == mpc_pkg::MON_DELAY_ADDR) ? mon_delay_ff : 8'h00;

  // boot walks the two eeprom locations in order
  always_comb begin
    nxt_boot = boot_ff;
    unique case (boot_ff)
      mpc_pkg::BOOT_PIN:   if (ee_rd_valid) nxt_boot = mpc_pkg::BOOT_DELAY;
      mpc_pkg::BOOT_DELAY: if (ee_rd_valid) nxt_boot = mpc_pkg::BOOT_RUN;
      mpc_pkg::BOOT_RUN:   nxt_boot = mpc_pkg::BOOT_RUN;
      default:             nxt_boot = mpc_pkg::BOOT_PIN;
    endcase
  end

  assign ee_rd_req  = booting;
  assign ee_rd_addr = (boot_ff == mpc_pkg::BOOT_PIN) ? mpc_pkg::PIN_FUNC_EE
                                                     : mpc_pkg::MON_DELAY_EE;
  assign reg_ready  = !booting;
  assign reg_rdata  = rdata_ff;

  // state and registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_ff      <= mpc_pkg::BOOT_PIN;
      pin_func_ff  <= mpc_pkg::PIN_FUNC_RST;
      mon_delay_ff <= mpc_pkg::MON_DELAY_RST;
      rdata_ff     <= 8'h00;
    end else begin
      boot_ff <= nxt_boot;
      if (ld_pin || wr_pin) begin
        pin_func_ff <= ld_pin ? ee_rd_data : reg_wdata;
      end
      if (ld_delay || wr_delay) begin
        mon_delay_ff <= ld_delay ? ee_rd_data : reg_wdata;
      end
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  //----------------------------------------------------------------------------
  // monitors
  //----------------------------------------------------------------------------
  wire [2:0] mode_1 = pin_func_ff[mpc_pkg::SUPERVISE_INPUT_FIRST_LSB +: 3];
  wire [2:0] mode_2 = mon_delay_ff[mpc_pkg::SUPERVISE_INPUT_SECOND_LSB +: 3];
  wire [2:0] mode_3 = mon_delay_ff[mpc_pkg::SUPERVISE_INPUT_THIRD_LSB +: 3];
  wire [8:0] modes  = {mode_3, mode_2, mode_1};
  wire [2:0] true_low = {(mode_3 == mpc_pkg::MODE_LINE0), 2'b00};

  // one decoder per monitor pin, fed straight from the live mode fields
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_mon
      mpc_monitor u_mon (
        .clk           (clk),
        .rst_n         (rst_n),
        .mode          (modes[gi*3 +: 3]),
        .line_true_low (true_low[gi]),
        .pin_hi        (pin_s[gi]),
        .above_115     (a115_s[gi]),
        .above_125     (a125_s[gi]),
        .above_135     (a135_s[gi]),
        .flag          (mon_flag[gi]),
        .ov            (mon_ov[gi]),
        .uv            (mon_uv[gi])
      );
    end
  endgenerate

  //----------------------------------------------------------------------------
  // power-on source, blanking start, serial pin role
  //----------------------------------------------------------------------------
  logic lgood_d_ff;
  logic scl_d_ff;
  wire  pson_pin   = (mode_3 == mpc_pkg::MODE_LINE0 || mode_3 == mpc_pkg::MODE_LINE1)
                     && mon_flag[2];
  wire  blank_line = pin_func_ff[mpc_pkg::BLANK_MODE_BIT];
  wire  line_rise  = lgood_s && !lgood_d_ff;
  wire  scl_fall   = !scl_s && scl_d_ff;

  assign serial_pins_mode = pin_func_ff[mpc_pkg::SERIAL_BIT];
  assign power_on_request = pin_func_ff[mpc_pkg::PSON_SRC_BIT] ? host_power_on_bit
                                                               : pson_pin;
  assign blank_start = blank_line ? line_rise : (scl_fall && serial_pins_mode);
  // link outputs drive the serial pins only outside bus mode
  assign sda_oe  = !serial_pins_mode;
  assign scl_oe  = !serial_pins_mode;
  assign sda_out = power_on_request;
  assign scl_out = lgood_s;

  // edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lgood_d_ff <= 1'b0;
      scl_d_ff   <= 1'b1;
    end else begin
      lgood_d_ff <= lgood_s;
      scl_d_ff   <= scl_s;
    end
  end

  //----------------------------------------------------------------------------
  // output-good turn-on delay
  //----------------------------------------------------------------------------
  logic [16:0] tick_cnt_ff;
  logic [10:0] ms_cnt_ff;
  logic        good_ff;
  wire  [10:0] dly_target = mpc_pkg::dly_ms(mon_delay_ff[mpc_pkg::DELAY_LSB +: 2]);
  wire         tick       = (tick_cnt_ff == 17'(TICK_CYCLES - 1));
  wire         dly_done   = (ms_cnt_ff >= dly_target);

  assign output_power_good = good_ff;

  // millisecond tick and count while the request stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 17'h00000;
      ms_cnt_ff   <= 11'h000;
      good_ff     <= 1'b0;
    end else if (!output_good_request) begin
      tick_cnt_ff <= 17'h00000;
      ms_cnt_ff   <= 11'h000;
      good_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= tick ? 17'h00000 : tick_cnt_ff + 17'h00001;
      if (tick && !dly_done) begin
        ms_cnt_ff <= ms_cnt_ff + 11'h001;
      end
      good_ff <= dly_done;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  boot_first_read_a: assert property (
    ld_pin |=> (pin_func_ff == $past(ee_rd_data)) && (ee_rd_addr == mpc_pkg::MON_DELAY_EE))
    else $error("first boot load wrong");
  boot_second_a: assert property (
    ld_delay |=> (mon_delay_ff == $past(ee_rd_data)) && reg_ready)
    else $error("second boot load wrong");
  pson_source_a: assert property (
    pin_func_ff[mpc_pkg::PSON_SRC_BIT] && $changed(host_power_on_bit)
    |-> power_on_request == host_power_on_bit)
    else $error("power-on source not host bit");
  blank_line_a: assert property (
    blank_line && $rose(lgood_s) |-> blank_start)
    else $error("blanking missed line recovery");
  blank_scl_a: assert property (
    blank_start && !blank_line |-> serial_pins_mode && $past(scl_s) && !scl_s)
    else $error("blanking start without scl fall");
  link_pins_a: assert property (
    !serial_pins_mode |-> sda_oe && scl_oe && sda_out == power_on_request)
    else $error("link outputs not driven");
  mon_pov_a: assert property (
    mode_1 == mpc_pkg::MODE_POV && a125_s[0] ##1 mode_1 == mpc_pkg::MODE_POV
    |-> mon_flag[0] && mon_ov[0] && !mon_uv[0])
    else $error("overvoltage monitor missed");
  line_sense_a: assert property (
    mode_2 == mpc_pkg::MODE_LINE0 |-> mon_flag[1] == pin_s[1])
    else $error("line sense flag wrong");
  delay_good_a: assert property (
    $rose(output_power_good) |-> $past(ms_cnt_ff) >= $past(dly_target))
    else $error("output good early");
  mode_write_a: assert property (
    wr_delay |=> mon_delay_ff == $past(reg_wdata))
    else $error("mode field not rewritten");

  boot_done_c:  cover property (ld_delay ##1 reg_ready);
  good_on_c:    cover property ($rose(output_power_good));
  blank_line_c: cover property (blank_start && blank_line);
  link_mode_c:  cover property (wr_pin ##1 !serial_pins_mode);
endmodule

// [tb/mpc_ee_model.sv]
`timescale 1ns/1ps
module mpc_ee_model #(
  parameter int         LAT      = 3,
  parameter logic [7:0] PIN_DATA = 8'hB3,
  parameter logic [7:0] DLY_DATA = 8'h4D
) (
  // clock
  input  wire logic        clk,
  // boot read port
  input  wire logic        ee_rd_req,
  input  wire logic [15:0] ee_rd_addr,
  output logic             ee_rd_valid,
  output logic      [7:0]  ee_rd_data
);
  // answers each pending read after LAT cycles with a one-cycle valid pulse
  initial begin
    ee_rd_valid = 1'b0;
    ee_rd_data  = 8'h00;
    forever begin
      @(negedge clk);
      if (ee_rd_req === 1'b1) begin
        repeat (LAT) @(negedge clk);
        ee_rd_valid = 1'b1;
        if (ee_rd_addr === mpc_pkg::PIN_FUNC_EE) begin
          ee_rd_data = PIN_DATA;
        end else if (ee_rd_addr === mpc_pkg::MON_DELAY_EE) begin
          ee_rd_data = DLY_DATA;
        end else begin
          ee_rd_data = 8'hA5;
        end
        @(negedge clk);
        ee_rd_valid = 1'b0;
        ee_rd_data  = ~ee_rd_data; // stale byte never lingers
      end
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  //----------------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------------
  logic        clk, resetn, reg_wr, reg_rd, reg_ready, ee_rd_req, ee_rd_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ee_rd_data;
  logic [15:0] ee_rd_addr;
  logic [2:0]  mon_pin_level, mon_above_115, mon_above_125, mon_above_135;
  logic [2:0]  mon_flag, mon_ov, mon_uv;
  logic        host_power_on_bit, line_power_good, output_good_request;
  logic        power_on_request, blank_start, output_power_good;
  logic        sda_out, sda_oe, scl_in, scl_out, scl_oe, serial_pins_mode;
  int          miscompares;
  int          n_checks;
  int          ms_tab [4] = '{400, 200, 800, 1600};

  mpc_top #(.TICK_CYCLES(4)) u_dut (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ready(reg_ready), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data),
    .mon_pin_level(mon_pin_level), .mon_above_115(mon_above_115),
    .mon_above_125(mon_above_125), .mon_above_135(mon_above_135),
    .mon_flag(mon_flag), .mon_ov(mon_ov), .mon_uv(mon_uv),
    .host_power_on_bit(host_power_on_bit), .line_power_good(line_power_good),
    .output_good_request(output_good_request),
    .power_on_request(power_on_request), .blank_start(blank_start),
    .output_power_good(output_power_good), .sda_in(1'b1), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .serial_pins_mode(serial_pins_mode)
  );

  mpc_ee_model #(.LAT(3)) u_ee (
    .clk(clk), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data)
  );

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // one-cycle read strobe, data sampled a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // counts blank pulses over a short window
  task automatic blanks(output int n);
    n = 0;
    repeat (10) begin
      @(negedge clk);
      if (blank_start === 1'b1) n++;
    end
  endtask

  // expected {flag, ov, uv} for a mode at a low or high input
  function automatic logic [2:0] exp_mon(logic [2:0] c, logic hi, logic third);
    case (c)
      3'h0: exp_mon = {(third ? ~hi : hi), 2'b00};
      3'h1: exp_mon = {hi, 2'b00};
      3'h2: exp_mon = hi ? 3'b110 : 3'b000;
      3'h3: exp_mon = hi ? 3'b100 : 3'b001;
      3'h4: exp_mon = hi ? 3'b100 : 3'b010;
      3'h5: exp_mon = hi ? 3'b101 : 3'b000;
      3'h6: exp_mon = hi ? 3'b100 : 3'b000;
      default: exp_mon = hi ? 3'b000 : 3'b100;
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int         n;
    int         cnt;
    clk = 1'b0; resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; mon_pin_level = 3'h0;
    mon_above_115 = 3'h0; mon_above_125 = 3'h0; mon_above_135 = 3'h0;
    host_power_on_bit = 1'b0; line_power_good = 1'b0;
    output_good_request = 1'b0; scl_in = 1'b1;
    miscompares = 0; n_checks = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    cnt = 0;
    while (reg_ready !== 1'b1 && cnt < 200) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 200) begin
      miscompares++;
      complete_run();
    end
    // boot image and register access
    rd(8'h0D, d); check(d, 8'hB3);
    rd(8'h0E, d); check(d, 8'h4D);
    check(ee_rd_req, 1'b0);
    wr(8'h20, 8'hFF); rd(8'h20, d); check(d, 8'h00);
    // every monitor mode at both input levels, mode rewritten on settled pins
    for (int c = 0; c < 8; c++) begin
      for (int h = 0; h < 2; h++) begin
        mon_pin_level = {3{h[0]}};
        mon_above_115 = {3{h[0]}};
        mon_above_125 = {3{h[0]}};
        mon_above_135 = {3{h[0]}};
        repeat (6) @(negedge clk);
        wr(8'h0D, {4'h0, c[2:0], 1'b1});
        wr(8'h0E, {c[2:0], c[2:0], 2'b01});
        for (int m = 0; m < 3; m++) begin
          check({mon_flag[m], mon_ov[m], mon_uv[m]}, exp_mon(c[2:0], h[0], m == 2));
        end
      end
    end
    rd(8'h0E, d); check(d, 8'hFD);
    // power-on source: pin path, then host bit
    wr(8'h0E, 8'hC1);
    wr(8'h0D, 8'h0D);
    mon_pin_level = 3'h0;
    repeat (5) @(negedge clk);
    check(power_on_request, 1'b1);
    wr(8'h0D, 8'h8D);
    check(power_on_request, 1'b0);
    host_power_on_bit = 1'b1;
    @(negedge clk);
    check(power_on_request, 1'b1);
    // blanking start events
    wr(8'h0D, 8'h1D);
    line_power_good = 1'b1;
    blanks(n); check(n, 1);
    wr(8'h0D, 8'h0D);
    line_power_good = 1'b0;
    repeat (6) @(negedge clk);
    line_power_good = 1'b1;
    blanks(n); check(n, 0);
    scl_in = 1'b0;
    blanks(n); check(n, 1);
    scl_in = 1'b1;
    check({serial_pins_mode, sda_oe, scl_oe}, 3'b100);
    wr(8'h0D, 8'h8C);
    repeat (6) @(negedge clk);
    scl_in = 1'b0;
    blanks(n); check(n, 0);
    check({serial_pins_mode, sda_oe, scl_oe}, 3'b011);
    check({sda_out, scl_out}, 2'b11);
    host_power_on_bit = 1'b0;
    line_power_good = 1'b0;
    repeat (6) @(negedge clk);
    check({sda_out, scl_out}, 2'b00);
    // output-good turn-on delay for each code, TICK_CYCLES of 4
    for (int k = 0; k < 4; k++) begin
      wr(8'h0E, {6'h36, k[1:0]});
      output_good_request = 1'b1;
      cnt = 0;
      while (output_power_good !== 1'b1 && cnt < 7000) begin
        @(negedge clk);
        cnt++;
      end
      if (cnt >= 7000) begin
        miscompares++;
        complete_run();
      end
      check(cnt >= ms_tab[k] * 4 && cnt <= ms_tab[k] * 4 + 4, 1'b1);
      output_good_request = 1'b0;
      repeat (3) @(negedge clk);
      check(output_power_good, 1'b0);
    end
    complete_run();
  end
endmodule
